// [rtl/fswid_device.sv]
// Flash device end: status-write, status-byte-2 write and identification read over the serial link.
//
// The address-and-strobe port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module fswid_device
  import fswid_pkg::*;
#(
  parameter logic [7:0] MFR_ID  = FSWID_MFR_DEFAULT,  // Arbitrary value.
  parameter logic [7:0] DEV1_ID = FSWID_DEV1_DEFAULT, // Arbitrary value.
  parameter logic [7:0] DEV2_ID = FSWID_DEV2_DEFAULT  // Arbitrary value.
) (
  input  wire logic clock,             // System clock.
  input  wire logic reset,             // Synchronous reset, active high.
  fswid_link_if.device link,           // Serial link.
  output logic      sector_lock_bit,   // Sector lock state.
  output logic      write_latch_bit,   // Write latch state.
  output logic      soft_reset_allow_bit, // Soft reset enable state.
  output logic      global_protect,    // Pulse: global protect performed.
  output logic      global_unprotect,  // Pulse: global unprotect performed.
  output logic      soft_reset_done    // Pulse: reset command honoured.
);
  typedef enum logic [1:0] {FSWID_IDLE, FSWID_DATA, FSWID_IDOUT, FSWID_IGNORE} fswid_state_type;

  logic [3:0] sync_lvl;
  logic [3:0] sync_rise;
  logic [3:0] sync_fall;
  fswid_state_type state_q, state_d;
  logic [7:0] shift_q;
  logic [2:0] bitcnt_q;
  logic [7:0] op_q;
  logic       have_data_q;
  logic [7:0] data_q;
  logic [1:0] idx_q;
  logic       id_done_q;
  logic       so_q;
  logic       so_oe_q;
  logic       lock_q, latch_q, allow_q;
  logic       gp_q, gu_q, srst_q;

  // Pins from the host's domain, serial data included, are synchronised before any use.
  // Active-low pins are inverted first so that the stages reset to the idle level of
  // each pin; otherwise reset release would look like a deselect edge.
  fswid_sync #(.W(4)) u_sync (
    .clock    (clock),
    .reset    (reset),
    .async_in ({~link.cs_n, link.sck, ~link.guard_n, link.si}),
    .sync_out (sync_lvl),
    .rise     (sync_rise),
    .fall     (sync_fall)
  );

  wire cs_act     = sync_lvl[3];
  wire cs_end     = sync_fall[3];
  wire sck_rise   = sync_rise[2] & cs_act;
  wire sck_fall   = sync_fall[2] & cs_act;
  wire guard_on   = sync_lvl[1];
  wire [7:0] byte_in = {shift_q[6:0], sync_lvl[0]};
  wire byte_done  = sck_rise & (bitcnt_q == 3'h7);
  wire on_bound   = (bitcnt_q == 3'h0);

  // Id byte table selection.
  wire [7:0] id_byte = (idx_q == 2'h0) ? MFR_ID :
                       (idx_q == 2'h1) ? DEV1_ID :
                       (idx_q == 2'h2) ? DEV2_ID : FSWID_EXT_LEN;

  wire [3:0] gp_code   = data_q[FSWID_GP_HI:FSWID_GP_LO];
  wire       do_gp     = (gp_code == FSWID_GP_PROTECT) & ~lock_q;
  wire       do_gu     = (gp_code == FSWID_GP_UNPROTECT) & ~lock_q;
  wire       guard_blk = guard_on & lock_q & ~data_q[FSWID_LOCK_POS];
  wire       is_sw1    = (op_q == FSWID_OP_STATUS_WRITE);
  wire       is_sw2    = (op_q == FSWID_OP_STATUS2_WRITE);

  // Frame state: opcode byte, then data or id output, else ignore.
  always_comb begin
    state_d = state_q;
    case (state_q)
      FSWID_IDLE: begin
        if (byte_done && (byte_in == FSWID_OP_ID_READ)) begin
          state_d = FSWID_IDOUT;
        end else if (byte_done && latch_q &&
                     (byte_in == FSWID_OP_STATUS_WRITE || byte_in == FSWID_OP_STATUS2_WRITE)) begin
          state_d = FSWID_DATA;
        end else if (byte_done) begin
          state_d = FSWID_IGNORE;
        end
      end
      FSWID_DATA:   if (byte_done) state_d = FSWID_IGNORE;
      FSWID_IDOUT:  state_d = FSWID_IDOUT;
      FSWID_IGNORE: state_d = FSWID_IGNORE;
      default:      state_d = FSWID_IDLE;
    endcase
    if (cs_end || !cs_act) begin
      state_d = FSWID_IDLE;
    end
  end

  always_ff @(posedge clock) begin
    if (reset || !cs_act) begin
      shift_q  <= 8'h00;
      bitcnt_q <= 3'h0;
    end else if (sck_rise) begin
      shift_q  <= byte_in;
      bitcnt_q <= bitcnt_q + 3'h1;
    end
  end

  // Latch opcode and the single data byte of the frame.
  always_ff @(posedge clock) begin
    if (reset || cs_end) begin
      op_q        <= 8'h00;
      have_data_q <= 1'b0;
      data_q      <= 8'h00;
    end else begin
      if (state_q == FSWID_IDLE && byte_done) op_q <= byte_in;
      if (state_q == FSWID_DATA && byte_done) begin
        data_q      <= byte_in;
        have_data_q <= 1'b1;
      end
    end
  end

  // State register.
  always_ff @(posedge clock) begin
    if (reset) state_q <= FSWID_IDLE;
    else       state_q <= state_d;
  end

  // id bytes shift out on falling sck after opcode; output goes out after byte 4 or deselect.
  always_ff @(posedge clock) begin
    if (reset || !cs_act || cs_end) begin
      idx_q     <= 2'h0;
      id_done_q <= 1'b0;
      so_q      <= 1'b0;
      so_oe_q   <= 1'b0;
    end else if (state_q == FSWID_IDOUT && sck_fall && !id_done_q) begin
      so_q    <= id_byte[~bitcnt_q];
      so_oe_q <= 1'b1;
    end else if (state_q == FSWID_IDOUT && byte_done) begin
      if (idx_q == 2'(FSWID_ID_BYTES - 1)) begin
        id_done_q <= 1'b1;
        so_oe_q   <= 1'b0;
      end
      idx_q <= idx_q + 2'h1;
    end
  end

  // Status bits update only on deselect, which closes every frame.
  always_ff @(posedge clock) begin
    if (reset) begin
      lock_q  <= 1'b0;
      latch_q <= 1'b0;
      allow_q <= 1'b0;
      gp_q    <= 1'b0;
      gu_q    <= 1'b0;
      srst_q  <= 1'b0;
    end else begin
      gp_q   <= 1'b0;
      gu_q   <= 1'b0;
      srst_q <= 1'b0;
      if (cs_end && on_bound && op_q == FSWID_OP_WRITE_ENABLE) begin
        latch_q <= 1'b1;
      end
      if (cs_end && on_bound && op_q == FSWID_OP_SOFT_RESET && allow_q) begin
        srst_q  <= 1'b1;
        latch_q <= 1'b0;
        lock_q  <= 1'b0;
      end
      if (cs_end && latch_q && is_sw1) begin
        latch_q <= 1'b0;
        if (have_data_q && !guard_blk) begin
          lock_q <= data_q[FSWID_LOCK_POS]; // lock bit
          gp_q   <= do_gp;
          gu_q   <= do_gu;
        end
      end
      if (cs_end && latch_q && is_sw2) begin
        latch_q <= 1'b0;
        if (have_data_q && on_bound) begin
          allow_q <= data_q[FSWID_ALLOW_POS]; // bit 4 only
        end
      end
    end
  end

  assign link.so_o            = so_q;
  assign link.so_oe           = so_oe_q;
  assign sector_lock_bit      = lock_q;
  assign write_latch_bit      = latch_q;
  assign soft_reset_allow_bit = allow_q;
  assign global_protect      = gp_q;
  assign global_unprotect    = gu_q;
  assign soft_reset_done     = srst_q;
endmodule

// [rtl/fswid_pkg.sv]
// Package with opcodes, bit positions, default id bytes, register offsets and timing counts for the flash status/id link.
package fswid_pkg;
  localparam logic [7:0] FSWID_OP_WRITE_ENABLE  = 8'h06;
  localparam logic [7:0] FSWID_OP_STATUS_WRITE  = 8'h01;
  localparam logic [7:0] FSWID_OP_STATUS2_WRITE = 8'h31;
  localparam logic [7:0] FSWID_OP_ID_READ       = 8'h9f;
  localparam logic [7:0] FSWID_OP_SOFT_RESET    = 8'hf0;
  localparam int         FSWID_LOCK_POS         = 7;
  localparam int         FSWID_GP_HI            = 5;
  localparam int         FSWID_GP_LO            = 2;
  localparam int         FSWID_ALLOW_POS        = 4;
  localparam logic [3:0] FSWID_GP_PROTECT       = 4'hf;
  localparam logic [3:0] FSWID_GP_UNPROTECT     = 4'h0;
  localparam logic [7:0] FSWID_EXT_LEN          = 8'h00;
  localparam int         FSWID_ID_BYTES         = 4;
  // Identity bytes below are arbitrary neutral values.
  localparam logic [7:0] FSWID_MFR_DEFAULT      = 8'ha5;
  localparam logic [7:0] FSWID_DEV1_DEFAULT     = 8'h5a;
  localparam logic [7:0] FSWID_DEV2_DEFAULT     = 8'h3c;
  localparam int         FSWID_CLK_NS           = 8;
  localparam int         FSWID_SCK_HALF_NS      = 40;
  localparam int         FSWID_SCK_HALF_CYC     = (FSWID_SCK_HALF_NS + FSWID_CLK_NS - 1) / FSWID_CLK_NS;
  // Host register offsets.
  localparam logic [3:0] FSWID_REG_CMD          = 4'h0;
  localparam logic [3:0] FSWID_REG_DATA         = 4'h1;
  localparam logic [3:0] FSWID_REG_CTRL         = 4'h2;
  localparam logic [3:0] FSWID_REG_STATUS       = 4'h3;
  localparam logic [3:0] FSWID_REG_RDATA        = 4'h4;
  localparam int         FSWID_CTRL_GO          = 0;
  localparam int         FSWID_CTRL_SENDDATA    = 1;
  localparam int         FSWID_CTRL_RDLEN_LO    = 4;
endpackage

// [rtl/fswid_link_if.sv]
// Interface joining the flash device end and the host controller end over the serial link.
`timescale 1ns/1ps
interface fswid_link_if;
  logic cs_n;   // Chip select, active low.
  logic sck;    // Serial clock from host.
  logic si;     // Serial data host to device.
  logic so_o;   // Serial data device to host.
  logic so_oe;  // Device drives so while high.
  logic guard_n; // Write guard pin, active low.
  wire  so = so_oe ? so_o : 1'b1;
  modport device (input cs_n, input sck, input si, input guard_n, output so_o, output so_oe);
  modport host   (output cs_n, output sck, output si, output guard_n, input so, input so_oe);
endinterface

// [rtl/fswid_sync.sv]
// Two-flop synchroniser with edge detection on the synchronised level.
`timescale 1ns/1ps
module fswid_sync #(
  parameter int W = 1
) (
  input  wire logic         clock,  // System clock.
  input  wire logic         reset,  // Synchronous reset.
  input  wire logic [W-1:0] async_in, // Level from another domain.
  output logic      [W-1:0] sync_out, // Synchronised level.
  output logic      [W-1:0] rise,   // One-cycle rising pulse.
  output logic      [W-1:0] fall    // One-cycle falling pulse.
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic [W-1:0] last_q;

  // Second and third stages only look at registered data.
  always_ff @(posedge clock) begin
    if (reset) begin
      meta_q <= '0;
      sync_q <= '0;
      last_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign sync_out = sync_q;
  assign rise     = sync_q & ~last_q;
  assign fall     = ~sync_q & last_q;
endmodule

// [rtl/fswid_host.sv]
// Host controller end: register-driven serial command engine for the flash link.
`timescale 1ns/1ps
module fswid_host
  import fswid_pkg::*;
(
  input  wire logic       clock,    // System clock.
  input  wire logic       reset,    // Synchronous reset, active high.
  input  wire logic [3:0] addr,     // Register address.
  input  wire logic [7:0] wdata,    // Write data.
  input  wire logic       wr,       // Write strobe.
  input  wire logic       rd,       // Read strobe.
  output logic      [7:0] rdata,    // Read data, cycle after rd.
  input  wire logic       guard_pin, // Drive write guard when high.
  fswid_link_if.host      link      // Serial link.
);
  typedef enum logic [1:0] {FSWID_H_IDLE, FSWID_H_LOW, FSWID_H_HIGH, FSWID_H_DONE} fswid_hstate_type;

  fswid_hstate_type st_q;
  logic [7:0] cmd_q, data_q, ctrl_q, rd_q, rdata_q;
  logic [7:0] tx_q, rx_q;
  logic [5:0] bits_q, total_q;
  logic [7:0] half_q;
  logic       sck_q, cs_n_q, so_meta_q, so_sync_q;

  wire busy    = (st_q != FSWID_H_IDLE);
  wire go      = wr && (addr == FSWID_REG_CTRL) && wdata[FSWID_CTRL_GO] && !busy;
  wire half_up = (half_q == 8'(FSWID_SCK_HALF_CYC - 1));
  // Frame length: opcode, optional data byte, plus read bytes (4 for a full id read).
  wire [5:0] nbits = 6'(8 + (wdata[FSWID_CTRL_SENDDATA] ? 8 : 0) + 8 * wdata[FSWID_CTRL_RDLEN_LO +: 3]);
  wire [7:0] rx_next = {rx_q[6:0], so_sync_q};

  // Register writes; ctrl holds options written with go.
  always_ff @(posedge clock) begin
    if (reset) begin
      cmd_q  <= 8'h00;
      data_q <= 8'h00;
      ctrl_q <= 8'h00;
    end else if (wr && !busy) begin
      if (addr == FSWID_REG_CMD)  cmd_q  <= wdata;
      if (addr == FSWID_REG_DATA) data_q <= wdata;
      if (addr == FSWID_REG_CTRL) ctrl_q <= wdata;
    end
  end

  // Returned serial data is synchronised before sampling.
  always_ff @(posedge clock) begin
    if (reset) begin
      so_meta_q <= 1'b1;
      so_sync_q <= 1'b1;
    end else begin
      so_meta_q <= link.so;
      so_sync_q <= so_meta_q;
    end
  end

  // Mode 0 engine: data changes while sck is low. Returned data is taken at the end of
  // the high phase, because the answer crosses a two-flop synchroniser on each side and is
  // not yet visible here when sck rises; the bit stands through the whole high phase.
  always_ff @(posedge clock) begin
    if (reset) begin
      st_q    <= FSWID_H_IDLE;
      sck_q   <= 1'b0;
      cs_n_q  <= 1'b1;
      half_q  <= 8'h00;
      bits_q  <= 6'h00;
      total_q <= 6'h00;
      tx_q    <= 8'h00;
      rx_q    <= 8'h00;
      rd_q    <= 8'h00;
    end else begin
      case (st_q)
        FSWID_H_IDLE: begin
          if (go) begin
            st_q    <= FSWID_H_LOW;
            cs_n_q  <= 1'b0;
            half_q  <= 8'h00;
            bits_q  <= 6'h00;
            total_q <= nbits;
            tx_q    <= cmd_q;
          end
        end
        FSWID_H_LOW: begin
          half_q <= half_q + 8'h01;
          if (half_up) begin
            half_q <= 8'h00;
            sck_q  <= 1'b1;
            st_q   <= FSWID_H_HIGH;
          end
        end
        FSWID_H_HIGH: begin
          half_q <= half_q + 8'h01;
          if (half_up) begin
            half_q <= 8'h00;
            sck_q  <= 1'b0;
            bits_q <= bits_q + 6'h01;
            tx_q   <= (bits_q == 6'h07) ? data_q : {tx_q[6:0], 1'b0};
            rx_q   <= rx_next;
            if (bits_q[2:0] == 3'h7) begin
              rd_q <= rx_next;
            end
            st_q <= (bits_q + 6'h01 == total_q) ? FSWID_H_DONE : FSWID_H_LOW;
          end
        end
        FSWID_H_DONE: begin
          half_q <= half_q + 8'h01;
          if (half_up) begin
            cs_n_q <= 1'b1;
            st_q   <= FSWID_H_IDLE;
          end
        end
        default: st_q <= FSWID_H_IDLE;
      endcase
    end
  end

  // Read mux, data valid the cycle after rd.
  wire [7:0] rmux = (addr == FSWID_REG_CMD)    ? cmd_q :
                    (addr == FSWID_REG_DATA)   ? data_q :
                    (addr == FSWID_REG_CTRL)   ? ctrl_q :
                    (addr == FSWID_REG_STATUS) ? {7'h00, busy} :
                    (addr == FSWID_REG_RDATA)  ? rd_q : 8'h00;
  always_ff @(posedge clock) begin
    if (reset)   rdata_q <= 8'h00;
    else if (rd) rdata_q <= rmux;
    else         rdata_q <= 8'h00;
  end

  assign rdata        = rdata_q;
  assign link.cs_n    = cs_n_q;
  assign link.sck     = sck_q;
  assign link.si      = tx_q[7];
  assign link.guard_n = ~guard_pin;
endmodule

// [tb/fswid_asserts.sv]
// Checker for the serial link joining the flash device end and the host end.
`timescale 1ns/1ps
module fswid_asserts
  import fswid_pkg::*;
#(
  parameter logic [31:0] ID = {FSWID_MFR_DEFAULT, FSWID_DEV1_DEFAULT, FSWID_DEV2_DEFAULT, FSWID_EXT_LEN}
) (
  input wire logic clock, // System clock.
  input wire logic reset, // Synchronous reset.
  input wire logic cs_n,  // Chip select, active low.
  input wire logic sck,   // Serial clock.
  input wire logic si,    // Host to device data.
  input wire logic so_o,  // Device data.
  input wire logic so_oe  // Device output enable.
);
  logic       sck_q;
  logic [6:0] rcnt_q;
  logic [7:0] sh_q;
  logic [7:0] opc_q;
  wire        rise  = sck & ~sck_q;
  wire  [7:0] nxt   = {sh_q[6:0], si};
  wire  [6:0] bix   = 7'h27 - rcnt_q;
  wire        id_on = ~cs_n && rcnt_q >= 7'h08 && opc_q == FSWID_OP_ID_READ;

  // Count raw clock rises in a frame; the raw pins lead what the device sees.
  always_ff @(posedge clock) begin
    sck_q <= sck;
    if (reset || cs_n) begin
      rcnt_q <= 7'h00;
      sh_q   <= 8'h00;
      opc_q  <= 8'h00;
    end else if (rise) begin
      rcnt_q <= rcnt_q + 7'h01;
      sh_q   <= nxt;
      if (rcnt_q == 7'h07) begin
        opc_q <= nxt;
      end
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  // Deselect needs a few cycles to pass the synchronisers.
  sequence s_desel;
    cs_n [*8];
  endsequence
  sequence s_out;
    so_oe && !cs_n;
  endsequence
  property p_off_desel;
    s_desel |-> !so_oe;
  endproperty
  property p_oe_late;
    s_out |-> rcnt_q >= 7'h08;
  endproperty
  property p_oe_id;
    s_out |-> opc_q == FSWID_OP_ID_READ;
  endproperty
  property p_oe_end;
    s_out |-> rcnt_q <= 7'h28;
  endproperty
  property p_id_bit;
    rise && id_on && rcnt_q <= 7'h27 |-> so_oe && so_o == ID[bix[4:0]];
  endproperty
  property p_so_hold;
    rise && so_oe |=> $stable(so_o) [*3];
  endproperty
  property p_sck_idle;
    cs_n |-> !sck;
  endproperty
  property p_whole;
    $rose(cs_n) |-> rcnt_q[2:0] == 3'h0;
  endproperty

  a_off_desel: assert property (p_off_desel)
    else $error("output driven after deselect");
  a_oe_late: assert property (p_oe_late)
    else $error("output driven before opcode end");
  a_oe_id: assert property (p_oe_id)
    else $error("output driven for a non id opcode");
  a_oe_end: assert property (p_oe_end)
    else $error("output driven after length byte");
  a_id_bit: assert property (p_id_bit)
    else $error("wrong id bit");
  a_so_hold: assert property (p_so_hold)
    else $error("output moved near sampling edge");
  a_sck_idle: assert property (p_sck_idle)
    else $error("serial clock high while deselected");
  a_whole: assert property (p_whole)
    else $error("frame ended off a byte boundary");
endmodule

// [tb/fswid_tb.sv]
// Testbench joining host and device ends, plus a bit-banged second device.
`timescale 1ns/1ps
module fswid_tb;
  import fswid_pkg::*;
  logic        clock = 1'b0;
  logic        reset = 1'b1;
  logic [3:0]  addr = 4'h0;
  logic [7:0]  wdata = 8'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        guard_pin = 1'b0;
  logic [7:0]  rdata;
  logic [7:0]  rv;
  logic        lock, latch, allow, gp, gu, srd, lock_b, latch_b, allow_b;
  logic [39:0] ide = {FSWID_MFR_DEFAULT, FSWID_DEV1_DEFAULT, FSWID_DEV2_DEFAULT, FSWID_EXT_LEN, 8'hff};
  int          miscompares = 0, checks = 0, n_gp = 0, n_gu = 0, n_srd = 0;
  wire  [7:0]  sa = {5'h00, lock, latch, allow};
  wire  [7:0]  sb = {5'h00, lock_b, latch_b, allow_b};
  fswid_link_if l1 ();
  fswid_link_if l2 ();
  fswid_host i_fswid_host (.clock(clock), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .guard_pin(guard_pin), .link(l1.host));
  fswid_device i_fswid_device (.clock(clock), .reset(reset), .link(l1.device), .sector_lock_bit(lock),
    .write_latch_bit(latch), .soft_reset_allow_bit(allow), .global_protect(gp), .global_unprotect(gu),
    .soft_reset_done(srd));
  fswid_device i_fswid_device_b (.clock(clock), .reset(reset), .link(l2.device), .sector_lock_bit(lock_b),
    .write_latch_bit(latch_b), .soft_reset_allow_bit(allow_b), .global_protect(), .global_unprotect(),
    .soft_reset_done());
  fswid_asserts i_fswid_asserts (.clock(clock), .reset(reset), .cs_n(l1.cs_n), .sck(l1.sck), .si(l1.si),
    .so_o(l1.so_o), .so_oe(l1.so_oe));

  // Clock and pulse counters; pulses last one cycle, so count them here.
  initial forever #4 clock = ~clock;
  always @(posedge clock) begin
    if (gp === 1'b1) n_gp <= n_gp + 1;
    if (gu === 1'b1) n_gu <= n_gu + 1;
    if (srd === 1'b1) n_srd <= n_srd + 1;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [3:0] a);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    @(negedge clock);
    rv = rdata;
  endtask
  // One host frame, then a bounded busy poll and time for the device update.
  task automatic frame(input logic [7:0] op, input logic [7:0] d, input logic [7:0] ctl);
    int k;
    k = 0;
    wreg(FSWID_REG_CMD, op);
    wreg(FSWID_REG_DATA, d);
    wreg(FSWID_REG_CTRL, ctl);
    do begin
      rreg(FSWID_REG_STATUS);
      k++;
    end while (rv[0] !== 1'b0 && k < 400);
    if (k >= 400) miscompares++;
    repeat (12) @(posedge clock);
  endtask
  task automatic wen();
    frame(FSWID_OP_WRITE_ENABLE, 8'h00, 8'h01);
  endtask
  // Bit-bang the second link so frames can stop off a byte boundary.
  task automatic bang(input logic [23:0] v, input int n);
    @(posedge clock);
    l2.cs_n <= 1'b0;
    for (int i = 0; i < n; i++) begin
      l2.si <= v[23-i];
      repeat (5) @(posedge clock);
      l2.sck <= 1'b1;
      repeat (5) @(posedge clock);
      l2.sck <= 1'b0;
    end
    repeat (5) @(posedge clock);
    l2.cs_n <= 1'b1;
    l2.si <= ~l2.si;
    repeat (12) @(posedge clock);
  endtask
  task automatic wrap_up();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Main sequence.
  initial begin
    l2.cs_n = 1'b1;
    l2.sck = 1'b0;
    l2.si = 1'b0;
    l2.guard_n = 1'b1;
    repeat (10) @(posedge clock);
    reset <= 1'b0;
    repeat (3) @(posedge clock);
    chk(sa, 8'h00);
    frame(FSWID_OP_STATUS_WRITE, 8'h80, 8'h03);
    chk(sa, 8'h00);
    $display("test reset and refusal done");
    wen();
    chk(sa, 8'h02);
    frame(FSWID_OP_STATUS_WRITE, 8'h00, 8'h13);
    chk(sa, 8'h00);
    chk(8'(n_gu), 8'h01);
    wen();
    frame(FSWID_OP_STATUS_WRITE, 8'hbc, 8'h03);
    chk(sa, 8'h04);
    chk(8'(n_gp), 8'h01);
    guard_pin <= 1'b1;
    wen();
    frame(FSWID_OP_STATUS_WRITE, 8'h3c, 8'h03);
    chk(sa, 8'h04);
    chk(8'(n_gp), 8'h01);
    guard_pin <= 1'b0;
    wen();
    frame(FSWID_OP_STATUS_WRITE, 8'h3c, 8'h03);
    chk(sa, 8'h00);
    chk(8'(n_gp), 8'h01);
    $display("test status write done");
    frame(FSWID_OP_SOFT_RESET, 8'h00, 8'h01);
    chk(8'(n_srd), 8'h00);
    wen();
    frame(FSWID_OP_STATUS2_WRITE, 8'h10, 8'h13);
    chk(sa, 8'h01);
    frame(FSWID_OP_SOFT_RESET, 8'h00, 8'h01);
    chk(8'(n_srd), 8'h01);
    wen();
    frame(FSWID_OP_STATUS_WRITE, 8'h80, 8'h03);
    chk(sa, 8'h05);
    chk(8'(n_gu), 8'h02);
    wen();
    frame(FSWID_OP_STATUS2_WRITE, 8'hef, 8'h03);
    chk(sa, 8'h04);
    $display("test reset allow done");
    for (int n = 1; n <= 5; n++) begin
      frame(FSWID_OP_ID_READ, 8'h00, {1'b0, 3'(n), 4'h1});
      rreg(FSWID_REG_RDATA);
      chk(rv, ide[47-8*n -: 8]);
    end
    rreg(FSWID_REG_CMD);
    chk(rv, FSWID_OP_ID_READ);
    $display("test id read done");
    bang({FSWID_OP_WRITE_ENABLE, 16'h0000}, 8);
    chk(sb, 8'h02);
    bang({FSWID_OP_STATUS_WRITE, 16'h8000}, 12);
    chk(sb, 8'h00);
    bang({FSWID_OP_WRITE_ENABLE, 16'h0000}, 8);
    bang({FSWID_OP_STATUS2_WRITE, 16'h1000}, 19);
    chk(sb, 8'h00);
    bang({FSWID_OP_WRITE_ENABLE, 16'h0000}, 8);
    bang({FSWID_OP_STATUS2_WRITE, 16'h1000}, 24);
    chk(sb, 8'h01);
    bang({FSWID_OP_ID_READ, 16'h0000}, 12);
    chk({7'h00, l2.so_oe}, 8'h00);
    $display("test aborts done");
    wrap_up();
  end

  // Watchdog well beyond the expected run of about 5400 cycles.
  initial begin
    repeat (80000) @(posedge clock);
    miscompares++;
    wrap_up();
  end
endmodule
